// [rtl/opamp_dac_map.vh]
`ifndef OPAMP_DAC_MAP_VH
`define OPAMP_DAC_MAP_VH

// Register byte offsets on the AXI4-Lite bus.
`define AMP1_CONTROL_OFS    4'h0
`define AMP2_CONTROL_OFS    4'h4
`define LADDER_CONTROL_OFS  4'h8
`define LADDER_LEVEL_OFS    4'hC

// Amplifier control fields.
`define AMP_EN_BIT          7
`define AMP_SPEED_BIT       6
`define AMP_UG_BIT          4
`define AMP_CH_HI           1
`define AMP_CH_LO           0
`define AMP_WRITE_MASK      8'hD3
`define AMP_RESET           8'h00

// Channel select codes.
`define CH_PIN              2'h0
`define CH_DAC2             2'h1
`define CH_DAC1             2'h2
`define CH_FIXED_REF        2'h3

// Ladder control fields.
`define LAD_EN_BIT          7
`define LAD_OE1_BIT         5
`define LAD_OE2_BIT         4
`define LAD_PSS_HI          3
`define LAD_PSS_LO          2
`define LAD_NSS_BIT         0
`define LAD_WRITE_MASK      8'hBD
`define LAD_RESET           8'h00
`define LEVEL_RESET         8'h00

// Positive source codes.
`define PSS_SUPPLY          2'h0
`define PSS_VREF_PIN        2'h1
`define PSS_FIXED_REF       2'h2
`define PSS_RESERVED        2'h3

// AXI responses.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// [rtl/amp_ctrl.v]
`timescale 1ns/1ns
`include "opamp_dac_map.vh"
module amp_ctrl (
    // Clock and reset.
    input  wire       clk,
    input  wire       rst_n,
    // Register write.
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    // Register read-back.
    output wire [7:0] ctrl_value,
    // Analog controls.
    output wire       amp_enable,
    output wire       amp_speed_select,
    output wire       unity_gain_select,
    output wire [1:0] noninv_channel_select,
    output wire       out_pin_digital_oe_n,
    output wire       inv_pin_connect
);

    reg [7:0] ctrl_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `AMP_RESET;
        end else if (wr_en) begin
            ctrl_r <= wr_data & `AMP_WRITE_MASK;
        end
    end

    assign ctrl_value            = ctrl_r;
    assign amp_enable            = ctrl_r[`AMP_EN_BIT];
    assign amp_speed_select      = ctrl_r[`AMP_SPEED_BIT];
    assign unity_gain_select     = ctrl_r[`AMP_UG_BIT];
    assign noninv_channel_select = ctrl_r[`AMP_CH_HI:`AMP_CH_LO];
    // The port driver is released while the amplifier drives the pin.
    assign out_pin_digital_oe_n  = ctrl_r[`AMP_EN_BIT];
    assign inv_pin_connect       = ~ctrl_r[`AMP_UG_BIT];

endmodule

// [rtl/opamp_dac_control.v]
// Overview of operation
// - Amp enable bit turns amp on and tri-states the output pin digital driver.
// - Speed bit 1 selects high bandwidth; 0, the reset default, low power.
// - Unity gain ties output to inverting input and frees the inverting pin.
// - Channel select: 11 fixed ref, 10 8-bit DAC, 01 5-bit DAC, 00 pin.
// - Any reset returns amp control registers to zero, disabling amps.
// - Unused amp control bits ignore writes and read as zero.
// - Ladder enable bit activates the voltage ladder; clear disables it.
// - Level code picks one of 256 taps while the ladder is enabled.
// - Positive source: 00 supply, 01 reference pin, 10 fixed ref, 11 reserved.
// - Negative source bit 1 selects reference pin, 0 selects ground.
// - Two output-enable bits each connect the ladder voltage to their pin.
// - A pin carrying ladder voltage loses digital buffers and reads zero.
// - Ladder keeps running in sleep; wake leaves its control unchanged.
// - Reset disables ladder, removes pin outputs, clears level code.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "opamp_dac_map.vh"
module opamp_dac_control (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst_n,
    // AXI4-Lite write address channel.
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response channel.
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data channel.
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Sleep state of the device.
    input  wire        sleep,
    // Amplifier 1 analog controls.
    output wire        amp1_enable,
    output wire        amp1_speed_select,
    output wire        amp1_unity_gain_select,
    output wire [1:0]  amp1_noninv_channel_select,
    output wire        amp1_output_pin_digital_oe_n,
    output wire        amp1_inverting_pin_connect,
    // Amplifier 2 analog controls.
    output wire        amp2_enable,
    output wire        amp2_speed_select,
    output wire        amp2_unity_gain_select,
    output wire [1:0]  amp2_noninv_channel_select,
    output wire        amp2_output_pin_digital_oe_n,
    output wire        amp2_inverting_pin_connect,
    // Ladder analog controls.
    output wire        ladder_enable,
    output wire [7:0]  ladder_level_code,
    output wire [1:0]  positive_source_select,
    output wire        negative_source_select,
    output wire        vout_pin1_enable,
    output wire        vout_pin2_enable,
    // Output pin digital override.
    input  wire        ref_out_pin1_in,
    input  wire        ref_out_pin2_in,
    output wire        ref_out_pin1_read,
    output wire        ref_out_pin2_read,
    output wire        ref_out_pin1_digital_off,
    output wire        ref_out_pin2_digital_off
);

    ////////////////////////////////////////////////////////////////////////////////
    reg        aw_held_r;
    reg [3:0]  aw_addr_r;
    reg        w_held_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;
    reg        rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0]  rresp_r;
    reg [7:0]  ladder_control_r;
    reg [7:0]  ladder_level_r;

    // Registered pad reads.
    reg        pin1_read_r;
    reg        pin2_read_r;

    wire       wr_fire;
    wire       wr_lane0;
    reg        wr_amp1;
    reg        wr_amp2;
    reg        wr_lad_ctl;
    reg        wr_lad_lvl;
    reg        wr_known;
    wire       rd_fire;
    wire [7:0] amp1_value;
    wire [7:0] amp2_value;
    reg  [7:0] rd_byte;
    reg        rd_known;

    // Word-aligned addresses and the data byte.
    wire [3:0] aw_word;
    wire [3:0] rd_addr;
    wire [7:0] wr_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // Address and data are taken in either order and held until both are in.
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign wr_fire       = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_lane0      = wr_fire & w_strb_r[0];
    assign aw_word       = {s_axi_awaddr[3:2], 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode on the held word address.
    always @* begin
        wr_amp1    = 1'b0;
        wr_amp2    = 1'b0;
        wr_lad_ctl = 1'b0;
        wr_lad_lvl = 1'b0;
        wr_known   = 1'b0;
        case (aw_addr_r)
            `AMP1_CONTROL_OFS: begin
                wr_amp1  = wr_lane0;
                wr_known = 1'b1;
            end
            `AMP2_CONTROL_OFS: begin
                wr_amp2  = wr_lane0;
                wr_known = 1'b1;
            end
            `LADDER_CONTROL_OFS: begin
                wr_lad_ctl = wr_lane0;
                wr_known   = 1'b1;
            end
            `LADDER_LEVEL_OFS: begin
                wr_lad_lvl = wr_lane0;
                wr_known   = 1'b1;
            end
            default: begin
                wr_known = 1'b0;
            end
        endcase
    end

    // Only byte lane 0 carries register data.
    assign wr_byte = w_data_r[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Address channel: one word address held until the write completes.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= aw_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data channel: held beside the address, in either order.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Response channel: raised by the write itself, dropped on bready.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Two identical amplifier channels.
    amp_ctrl u_amp1 (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .wr_en                 (wr_amp1),
        .wr_data               (w_data_r[7:0]),
        .ctrl_value            (amp1_value),
        .amp_enable            (amp1_enable),
        .amp_speed_select      (amp1_speed_select),
        .unity_gain_select     (amp1_unity_gain_select),
        .noninv_channel_select (amp1_noninv_channel_select),
        .out_pin_digital_oe_n  (amp1_output_pin_digital_oe_n),
        .inv_pin_connect       (amp1_inverting_pin_connect)
    );

    amp_ctrl u_amp2 (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .wr_en                 (wr_amp2),
        .wr_data               (w_data_r[7:0]),
        .ctrl_value            (amp2_value),
        .amp_enable            (amp2_enable),
        .amp_speed_select      (amp2_speed_select),
        .unity_gain_select     (amp2_unity_gain_select),
        .noninv_channel_select (amp2_noninv_channel_select),
        .out_pin_digital_oe_n  (amp2_output_pin_digital_oe_n),
        .inv_pin_connect       (amp2_inverting_pin_connect)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Ladder registers. Sleep does not touch them; only reset and writes do.
    // Control bits survive sleep; only reset and writes change them.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ladder_control_r <= `LAD_RESET;
        end else if (wr_lad_ctl) begin
            ladder_control_r <= wr_byte & `LAD_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The level code is cleared by reset and set by writes alone.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ladder_level_r <= `LEVEL_RESET;
        end else if (wr_lad_lvl) begin
            ladder_level_r <= wr_byte;
        end
    end

    // The sleep input is deliberately unused: the ladder runs on through sleep.
    assign ladder_enable          = ladder_control_r[`LAD_EN_BIT] | (sleep & 1'b0);
    assign ladder_level_code      = ladder_level_r;
    assign positive_source_select = ladder_control_r[`LAD_PSS_HI:`LAD_PSS_LO];
    assign negative_source_select = ladder_control_r[`LAD_NSS_BIT];
    assign vout_pin1_enable       = ladder_control_r[`LAD_OE1_BIT];
    assign vout_pin2_enable       = ladder_control_r[`LAD_OE2_BIT];

    // A pin carrying ladder voltage has its digital buffers off and reads low.
    assign ref_out_pin1_digital_off = vout_pin1_enable;
    assign ref_out_pin2_digital_off = vout_pin2_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // The pad level is registered so that the read value is a flop output.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_read_r <= 1'b0;
            pin2_read_r <= 1'b0;
        end else begin
            pin1_read_r <= ref_out_pin1_in & ~vout_pin1_enable;
            pin2_read_r <= ref_out_pin2_in & ~vout_pin2_enable;
        end
    end

    assign ref_out_pin1_read = pin1_read_r;
    assign ref_out_pin2_read = pin2_read_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address acceptance to data.
    assign s_axi_arready = ~rvalid_r;
    assign rd_fire       = s_axi_arvalid & ~rvalid_r;
    assign rd_addr       = {s_axi_araddr[3:2], 2'b00};

    // Read decode; unused bits read as zero since they are never stored.
    always @* begin
        rd_byte  = 8'h00;
        rd_known = 1'b0;
        case (rd_addr)
            `AMP1_CONTROL_OFS: begin
                rd_byte  = amp1_value;
                rd_known = 1'b1;
            end
            `AMP2_CONTROL_OFS: begin
                rd_byte  = amp2_value;
                rd_known = 1'b1;
            end
            `LADDER_CONTROL_OFS: begin
                rd_byte  = ladder_control_r;
                rd_known = 1'b1;
            end
            `LADDER_LEVEL_OFS: begin
                rd_byte  = ladder_level_r;
                rd_known = 1'b1;
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    // Read valid: raised by the request, dropped on rready.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and response, captured with the request.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
        end else if (rd_fire) begin
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

endmodule

// [dv/opamp_dac_checker.sv]
`timescale 1ns/1ns
module opamp_dac_checker (
    // Clock, reset and bus.
    input wire        clk,
    input wire        rst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [3:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    // Analog controls.
    input wire        amp1_enable,
    input wire        amp1_speed_select,
    input wire        amp1_unity_gain_select,
    input wire [1:0]  amp1_noninv_channel_select,
    input wire        amp1_output_pin_digital_oe_n,
    input wire        amp1_inverting_pin_connect,
    input wire        amp2_unity_gain_select,
    input wire        amp2_inverting_pin_connect,
    input wire        ladder_enable,
    input wire [7:0]  ladder_level_code,
    input wire        vout_pin1_enable,
    input wire        ref_out_pin1_in,
    input wire        ref_out_pin1_read,
    input wire        ref_out_pin1_digital_off
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    amp_oe_a: assert property (amp1_output_pin_digital_oe_n == amp1_enable)
        else $error("amp1 port driver not released");
    inv_pin_a: assert property (amp1_inverting_pin_connect != amp1_unity_gain_select)
        else $error("amp1 inverting pin routing wrong");
    amp2_inv_a: assert property (amp2_inverting_pin_connect != amp2_unity_gain_select)
        else $error("amp2 inverting pin routing wrong");
    pin_read_a: assert property ($past(rst_n) |-> ref_out_pin1_read == ($past(ref_out_pin1_in) & !$past(vout_pin1_enable)))
        else $error("pin1 read not forced low");
    pin_off_a: assert property (ref_out_pin1_digital_off == vout_pin1_enable)
        else $error("pin1 digital buffers not overridden");
    hold_ladder_a: assert property (!$rose(s_axi_bvalid) |-> $stable({ladder_enable, ladder_level_code}))
        else $error("ladder controls moved without a write");
    hold_amp_a: assert property (!$rose(s_axi_bvalid) |-> $stable({amp1_enable, amp1_noninv_channel_select}))
        else $error("amp1 controls moved without a write");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    rd_amp_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0 |=> s_axi_rdata == {24'h0, $past(amp1_enable), $past(amp1_speed_select), 1'b0, $past(amp1_unity_gain_select), 2'h0, $past(amp1_noninv_channel_select)})
        else $error("amp1 read-back wrong");
endmodule
bind opamp_dac_control opamp_dac_checker i_opamp_dac_checker (.*);

// [dv/pin_model.sv]
`timescale 1ns/1ns
module pin_model (
    // Clock.
    input  wire clk,
    // Pad levels seen by the digital input.
    output reg  pin1_level,
    output reg  pin2_level
);
    // Pads keep changing so a forced-low read cannot pass by chance.
    initial begin
        pin1_level = 1'b1;
        pin2_level = 1'b0;
    end
    always @(posedge clk) begin
        pin1_level <= ~pin1_level;
        pin2_level <= pin1_level;
    end
endmodule

// [dv/opamp_dac_control_test.sv]
`timescale 1ns/1ns
`include "opamp_dac_map.vh"
module opamp_dac_control_test;
    reg        clk, rst_n, sleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg        s_axi_arvalid, s_axi_rready;
    reg [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, amp1_noninv_channel_select;
    wire [1:0] amp2_noninv_channel_select, positive_source_select;
    wire [31:0] s_axi_rdata;
    wire       amp1_enable, amp1_speed_select, amp1_unity_gain_select;
    wire       amp1_output_pin_digital_oe_n, amp1_inverting_pin_connect;
    wire       amp2_enable, amp2_speed_select, amp2_unity_gain_select;
    wire       amp2_output_pin_digital_oe_n, amp2_inverting_pin_connect;
    wire       ladder_enable, negative_source_select, vout_pin1_enable, vout_pin2_enable;
    wire [7:0] ladder_level_code;
    wire       ref_out_pin1_in, ref_out_pin2_in, ref_out_pin1_read, ref_out_pin2_read;
    wire       ref_out_pin1_digital_off, ref_out_pin2_digital_off;
    reg [7:0]  m [0:3];
    integer    fail_count, compares, i, done;
    reg [31:0] r;
    reg        p1, p2;
    opamp_dac_control i_opamp_dac_control (.*);
    pin_model i_pin_model (.clk(clk), .pin1_level(ref_out_pin1_in), .pin2_level(ref_out_pin2_in));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        p1 <= ref_out_pin1_in;
        p2 <= ref_out_pin2_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    task chk(input [8*6:1] n, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0s expected %h seen %h", n, exp, seen);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d, input [3:0] s);
        begin
            r = $urandom;
            if (s[0]) m[a[3:2]] = d & (a[3] ? (a[2] ? 8'hFF : 8'hBD) : 8'hD3);
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {r[31:8], d};
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            done = 0;
            while (!done) begin
                @(posedge clk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) begin
                    done = 1;
                    s_axi_bready <= 1'b0;
                    chk("bresp", s_axi_bresp, `RESP_OKAY);
                end
            end
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            done = 0;
            while (!done) begin
                @(posedge clk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) begin
                    done = 1;
                    s_axi_rready <= 1'b0;
                    chk("rdata", s_axi_rdata, {24'h0, m[a[3:2]]});
                    chk("rresp", s_axi_rresp, `RESP_OKAY);
                end
            end
        end
    endtask
    task outs;
        begin
            @(negedge clk);
            chk("amp1", {amp1_enable, amp1_speed_select, amp1_unity_gain_select, amp1_noninv_channel_select}, {m[0][7:6], m[0][4], m[0][1:0]});
            chk("amp2", {amp2_enable, amp2_speed_select, amp2_output_pin_digital_oe_n, amp2_noninv_channel_select}, {m[1][7:6], m[1][7], m[1][1:0]});
            chk("ladctl", {ladder_enable, vout_pin1_enable, vout_pin2_enable, positive_source_select, negative_source_select}, {m[2][7], m[2][5:2], m[2][0]});
            chk("level", ladder_level_code, m[3]);
            chk("pins", {ref_out_pin1_read, ref_out_pin2_read, ref_out_pin1_digital_off, ref_out_pin2_digital_off}, {p1 & ~m[2][5], p2 & ~m[2][4], m[2][5:4]});
        end
    endtask
    task close_out;
        begin
            $display("mismatches %0d comparisons %0d", fail_count, compares);
            if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        fail_count = fail_count + 1;
        close_out;
    end
    initial begin
        {clk, rst_n, sleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = 14'h0;
        s_axi_wdata = 32'h0;
        {fail_count, compares} = 64'h0;
        for (i = 0; i < 4; i = i + 1) m[i] = 8'h00;
        r = $urandom(3224);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) rd(i * 4);
        outs;
        for (i = 0; i < 4; i = i + 1) begin
            r = $urandom;
            wr(4'h0, {r[7:2], i[1:0]}, 4'h1);
            wr(4'h4, {r[15:10], ~i[1:0]}, 4'h1);
            wr(4'h8, {r[23:20], i[1:0], r[17:16]}, 4'h1);
            outs;
        end
        for (i = 0; i < 30; i = i + 1) begin
            r = $urandom;
            wr({r[1:0], 2'h0}, r[15:8], {3'h0, r[4:2] != 3'h0});
            outs;
            rd({r[1:0], 2'h0});
        end
        wr(4'h6, 8'hFF, 4'h1);
        rd(4'h6);
        wr(4'h8, m[2] & 8'h7F, 4'h1);
        @(posedge clk);
        sleep <= 1'b1;
        repeat (20) @(posedge clk);
        sleep <= 1'b0;
        for (i = 0; i < 4; i = i + 1) rd(i * 4);
        outs;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) m[i] = 8'h00;
        for (i = 0; i < 4; i = i + 1) rd(i * 4);
        outs;
        close_out;
    end
endmodule
